// ### design/pccd_top.sv
// Power-condition and cache-flush command decoder, one APB slave.
// Assumes firmware loads CDB bytes 0..9, pulses GO and polls status;
// the flush engine outside answers flush_req with flush_done_in.
// Functional notes
// - Start bit used only for code/modifier zero
// - Code 0 modifier 0 processes start bit
// - Code 1 modifier 0 enters active
// - Code 2 selects idle a, b, c
// - Code 3 selects standby z or y
// - Code 7 hands control to timers
// - Code A zeroes an idle timer
// - Code B zeroes a standby timer
// - Explicit request enters exactly selected state
// - Explicit request disables timers until handback
// - Unload limits apply only under timer control
// - Handback starts supported and enabled idle timers only
// - Handback: idle timers on, standby kept off
// - Force zeroes timer, enters state, handback
// - Force on unsupported/inactive timer is illegal
// - Entering current state is no error
// - Start bit 0 stops, 1 starts
// - After ready, accept command in any motor state
// - Opcode 35h: LBA bytes 2-5, count 7-8
// - Flush writes all cached blocks in range
// - Status withheld until flush completes
// - Flush immediate bit set is illegal
// - Zero count means through last block
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pccd_top
    import pccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic flush_done_in,
    output logic flush_req,
    output logic [31:0] flush_lba,
    output logic [31:0] flush_count,
    output pccd_spindle_t spindle,
    output pccd_pstate_t power_state,
    output logic timer_governed_power,
    output logic unload_limits_on,
    output logic [TI_NUM-1:0] timers_active,
    output logic [TI_NUM-1:0] timer_zero_pulse,
    output logic cmd_done
);

    logic [31:0] cdb0;
    logic [31:0] cdb1;
    logic [31:0] cdb2;
    logic [31:0] timer_cfg;
    logic [31:0] last_block;
    logic go;
    logic [1:0] ready_sync;
    logic drive_ready;
    logic [1:0] flush_sync;
    logic flush_done;
    pccd_fsm_t state;
    pccd_fsm_t next_state;
    pccd_result_t result;
    pccd_result_t next_result;
    logic busy;

    // CDB fields
    logic [7:0] opcode;
    logic [3:0] pc_code;
    logic [3:0] pc_mod;
    logic start_bit;
    logic media_eject_bit;
    logic flush_immed;
    logic [31:0] cdb_lba;
    logic [15:0] cdb_count;
    logic [4:0] tmr_sup;
    logic [4:0] tmr_en;

    assign opcode = cdb0[7:0];
    assign pc_mod = cdb0[27:24];
    assign pc_code = cdb1[7:4];
    assign media_eject_bit = cdb1[1];
    assign start_bit = cdb1[0];
    assign flush_immed = cdb0[9];
    assign cdb_lba = {cdb0[23:16], cdb0[31:24], cdb1[7:0], cdb1[15:8]};
    assign cdb_count = {cdb1[31:24], cdb2[7:0]};
    assign tmr_sup = timer_cfg[TMR_SUP_LSB +: TI_NUM];
    assign tmr_en = timer_cfg[TMR_EN_LSB +: TI_NUM];
    assign busy = (state != PCCD_IDLE);

    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
        byte_of = w[i*8 +: 8];
    endfunction : byte_of

    function automatic pccd_result_t check_cond();
        check_cond = '{status: ST_CHECK, sense_key: SK_ILLEGAL_REQ, asc: ASC_INVALID_CDB};
    endfunction : check_cond

    function automatic pccd_result_t good();
        good = '{status: ST_GOOD, sense_key: SK_NONE, asc: ASC_NONE};
    endfunction : good

    // GO pulse and the flush_done_in pin, two flops each
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ready_sync <= 2'b00;
            flush_sync <= 2'b00;
        end else begin
            ready_sync <= {ready_sync[0], go};
            flush_sync <= {flush_sync[0], flush_done_in};
        end
    end
    assign flush_done = flush_sync[1];

    // APB slave, one wait state in the access phase
    logic apb_access;
    logic apb_commit;
    assign apb_access = psel && penable && !pready;
    // Writes land only at the edge that completes the access
    assign apb_commit = psel && penable && pready && pwrite;

    // APB response; read data loaded with pready so it stands at completion
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_access;
            pslverr <= 1'b0;
            if (apb_access) begin
                case (paddr)
                    REG_CDB0: prdata <= cdb0;
                    REG_CDB1: prdata <= cdb1;
                    REG_CDB2: prdata <= cdb2;
                    REG_CTRL: prdata <= {29'h0, flush_done, drive_ready, busy};
                    REG_STATUS: prdata <= {12'h0, result};
                    REG_TIMERS: prdata <= {8'h00, 3'h0, timers_active, timer_cfg[15:0]};
                    REG_LAST_BLOCK: prdata <= last_block;
                    REG_FLUSH_LBA: prdata <= flush_lba;
                    REG_FLUSH_CNT: prdata <= flush_count;
                    default: begin
                        prdata <= '0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Register writes; CDB words frozen while a command runs
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cdb0 <= '0;
            cdb1 <= '0;
            cdb2 <= '0;
            timer_cfg <= {16'h0000, 3'h0, TMR_RESET_EN, 3'h0, TMR_RESET_SUP};
            last_block <= LAST_BLOCK_RESET;
            go <= 1'b0;
            drive_ready <= 1'b0;
        end else begin
            go <= 1'b0;
            if (apb_commit) begin
                case (paddr)
                    REG_CDB0: if (!busy) cdb0 <= pwdata;
                    REG_CDB1: if (!busy) cdb1 <= pwdata;
                    REG_CDB2: if (!busy) cdb2 <= pwdata;
                    REG_CTRL: begin
                        go <= pwdata[CTRL_GO] && !busy;
                        drive_ready <= pwdata[CTRL_READY];
                    end
                    REG_TIMERS: timer_cfg <= pwdata & 32'h00001F1F;
                    REG_LAST_BLOCK: last_block <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // Decode; combinational verdict for the current CDB
    logic bad;
    logic is_flush;
    logic is_force;
    logic [2:0] tgt_idx;
    pccd_pstate_t tgt_state;
    always_comb begin
        bad = 1'b0;
        is_flush = 1'b0;
        is_force = 1'b0;
        tgt_idx = 3'h0;
        tgt_state = power_state;
        if (opcode == OPC_FLUSH10) begin
            bad = flush_immed;
            is_flush = 1'b1;
        end else if (opcode == OPC_START_STOP) begin
            case (pc_code)
                PC_START_VALID: bad = (pc_mod != MOD_0);
                PC_ACTIVE: begin
                    bad = (pc_mod != MOD_0);
                    tgt_state = PCCD_PS_ACTIVE;
                end
                PC_IDLE: begin
                    bad = (pc_mod > MOD_2);
                    tgt_state = pccd_pstate_t'(3'(pc_mod[1:0]) + 3'h1);
                end
                PC_STANDBY: begin
                    bad = (pc_mod > MOD_1);
                    tgt_state = pc_mod[0] ? PCCD_PS_STBY_Y : PCCD_PS_STBY_Z;
                end
                PC_HAND_BACK: bad = (pc_mod != MOD_0);
                PC_FORCE_IDLE: begin
                    is_force = 1'b1;
                    tgt_idx = 3'(pc_mod[1:0]);
                    bad = (pc_mod > MOD_2);
                    tgt_state = pccd_pstate_t'(3'(pc_mod[1:0]) + 3'h1);
                end
                PC_FORCE_STBY: begin
                    is_force = 1'b1;
                    tgt_idx = 3'(TI_STBY_Z) + 3'(pc_mod[0]);
                    bad = (pc_mod > MOD_1);
                    tgt_state = pc_mod[0] ? PCCD_PS_STBY_Y : PCCD_PS_STBY_Z;
                end
                default: bad = 1'b1;
            endcase
            if (is_force && !bad && !(tmr_sup[tgt_idx] && timers_active[tgt_idx])) begin
                bad = 1'b1;
            end
        end else begin
            bad = 1'b1;
        end
    end

    // Command sequencer
    always_comb begin
        next_state = state;
        next_result = result;
        case (state)
            PCCD_IDLE: if (ready_sync[1]) next_state = PCCD_DECODE;
            PCCD_DECODE: begin
                if (bad) begin
                    next_result = check_cond();
                    next_state = PCCD_STATUS;
                end else begin
                    // current state or motor state never an error
                    next_result = good();
                    next_state = is_flush ? PCCD_FLUSH : PCCD_STATUS;
                end
            end
            // status held back until flush done
            PCCD_FLUSH: if (flush_done) next_state = PCCD_STATUS;
            PCCD_STATUS: next_state = PCCD_IDLE;
            default: next_state = PCCD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= PCCD_IDLE;
            result <= '0;
            cmd_done <= 1'b0;
        end else begin
            state <= next_state;
            result <= next_result;
            cmd_done <= (state == PCCD_STATUS);
        end
    end

    logic apply;
    assign apply = (state == PCCD_DECODE) && !bad && (opcode == OPC_START_STOP) && drive_ready;

    // Power state and timer control
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_state <= PCCD_PS_ACTIVE;
            timer_governed_power <= 1'b1;
            unload_limits_on <= 1'b1;
            timers_active <= TMR_RESET_SUP & TMR_RESET_EN;
            timer_zero_pulse <= '0;
            spindle <= '0;
        end else begin
            timer_zero_pulse <= '0;
            spindle <= '0;
            if (apply) begin
                case (pc_code)
                    PC_START_VALID: begin
                        spindle.valid <= 1'b1;
                        spindle.start <= start_bit;
                        spindle.stop <= !start_bit;
                    end
                    PC_ACTIVE, PC_IDLE, PC_STANDBY: begin
                        power_state <= tgt_state;
                        timer_governed_power <= 1'b0;
                        unload_limits_on <= 1'b0;
                        timers_active <= '0;
                    end
                    PC_HAND_BACK: begin
                        timer_governed_power <= 1'b1;
                        unload_limits_on <= 1'b1;
                        timers_active <= tmr_sup & tmr_en & TMR_IDLE_MASK;
                    end
                    // zero timer, enter state, hand back
                    default: begin
                        timer_zero_pulse[tgt_idx] <= 1'b1;
                        power_state <= tgt_state;
                        timer_governed_power <= 1'b1;
                        unload_limits_on <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Flush request to the cache engine
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flush_req <= 1'b0;
            flush_lba <= '0;
            flush_count <= '0;
        end else if (state == PCCD_DECODE && is_flush && !bad) begin
            flush_req <= 1'b1;
            flush_lba <= cdb_lba;
            // zero count runs to last block
            flush_count <= (cdb_count == CNT_ZERO) ? (last_block - cdb_lba + 32'h1) : {16'h0, cdb_count};
        end else if (state == PCCD_FLUSH && flush_done) begin
            flush_req <= 1'b0;
        end
    end

endmodule : pccd_top

// ### design/pccd_pkg.sv
// Package for the power-condition command decoder: codes, sense values,
// APB register map and the carrier structs shared with the top module.
// Assumes a single 40 MHz core clock domain.
package pccd_pkg;

    // Command opcodes
    localparam logic [7:0] OPC_START_STOP = 8'h1B;
    localparam logic [7:0] OPC_FLUSH10 = 8'h35;

    // Power-condition codes
    localparam logic [3:0] PC_START_VALID = 4'h0;
    localparam logic [3:0] PC_ACTIVE = 4'h1;
    localparam logic [3:0] PC_IDLE = 4'h2;
    localparam logic [3:0] PC_STANDBY = 4'h3;
    localparam logic [3:0] PC_HAND_BACK = 4'h7;
    localparam logic [3:0] PC_FORCE_IDLE = 4'hA;
    localparam logic [3:0] PC_FORCE_STBY = 4'hB;

    // Modifiers
    localparam logic [3:0] MOD_0 = 4'h0;
    localparam logic [3:0] MOD_1 = 4'h1;
    localparam logic [3:0] MOD_2 = 4'h2;

    // Sense data
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_INVALID_CDB = 8'h24;
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;

    // APB byte offsets
    localparam logic [7:0] REG_CDB0 = 8'h00;
    localparam logic [7:0] REG_CDB1 = 8'h04;
    localparam logic [7:0] REG_CDB2 = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_TIMERS = 8'h14;
    localparam logic [7:0] REG_LAST_BLOCK = 8'h18;
    localparam logic [7:0] REG_FLUSH_LBA = 8'h1C;
    localparam logic [7:0] REG_FLUSH_CNT = 8'h20;

    // Control register bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_READY = 1;
    localparam int CTRL_FLUSH_DONE = 2;

    // Timer register layout: bits 4:0 supported, 12:8 enabled
    localparam int TMR_SUP_LSB = 0;
    localparam int TMR_EN_LSB = 8;
    localparam int TMR_ACT_LSB = 16;
    localparam logic [4:0] TMR_RESET_SUP = 5'h1F;
    localparam logic [4:0] TMR_RESET_EN = 5'h1F;

    // Timer index: idle a,b,c then standby z,y
    localparam int TI_IDLE_A = 0;
    localparam int TI_STBY_Z = 3;
    localparam int TI_NUM = 5;
    localparam logic [4:0] TMR_IDLE_MASK = 5'h07;
    localparam logic [4:0] TMR_STBY_MASK = 5'h18;

    localparam logic [31:0] LAST_BLOCK_RESET = 32'hFFFFFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        PCCD_PS_ACTIVE = 3'h0,
        PCCD_PS_IDLE_A = 3'h1,
        PCCD_PS_IDLE_B = 3'h2,
        PCCD_PS_IDLE_C = 3'h3,
        PCCD_PS_STBY_Z = 3'h4,
        PCCD_PS_STBY_Y = 3'h5
    } pccd_pstate_t;

    // Gray along idle -> decode -> flush -> status
    typedef enum logic [1:0] {
        PCCD_IDLE = 2'b00,
        PCCD_DECODE = 2'b01,
        PCCD_FLUSH = 2'b11,
        PCCD_STATUS = 2'b10
    } pccd_fsm_t;

    typedef struct packed {
        logic [7:0] status;
        logic [3:0] sense_key;
        logic [7:0] asc;
    } pccd_result_t;

    typedef struct packed {
        logic valid;
        logic start;
        logic stop;
    } pccd_spindle_t;

endpackage : pccd_pkg

// ### dv/pccd_chk.sv
// Port checker for the power-condition decoder.
// Assumes one clock domain and the async low reset.
`timescale 1ns/1ps
module pccd_chk
    import pccd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic flush_done_in,
    input wire logic flush_req,
    input wire logic [31:0] flush_lba,
    input wire logic [31:0] flush_count,
    input wire pccd_spindle_t spindle,
    input wire logic timer_governed_power,
    input wire logic unload_limits_on,
    input wire logic [TI_NUM-1:0] timers_active,
    input wire logic [TI_NUM-1:0] timer_zero_pulse,
    input wire logic cmd_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        ##[1:3] pready;
    endsequence
    a_apb_answer: assert property (s_setup |-> s_answer)
        else $error("access not answered");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unload_track: assert property (unload_limits_on == timer_governed_power)
        else $error("unload limits differ from timer control");
    a_timers_held: assert property (!timer_governed_power && $past(!timer_governed_power) |-> timers_active == 5'h00)
        else $error("timer running under initiator control");
    a_flush_wait: assert property (flush_req && !flush_done_in |=> flush_req)
        else $error("flush dropped before completion");
    a_flush_end: assert property (flush_req && flush_done_in |-> ##[1:4] !flush_req)
        else $error("flush request not ended");
    a_flush_stable: assert property (flush_req && $past(flush_req) |-> $stable(flush_lba) && $stable(flush_count))
        else $error("flush range moved");
    a_spin_dir: assert property (spindle.valid |-> spindle.start ^ spindle.stop)
        else $error("spindle direction ambiguous");
    a_done_pulse: assert property (cmd_done |=> !cmd_done)
        else $error("done longer than one cycle");
    a_done_after_flush: assert property (cmd_done |-> !flush_req)
        else $error("status during flush");
    a_force_back: assert property (|timer_zero_pulse |=> timer_zero_pulse == 5'h00 && timer_governed_power)
        else $error("force did not hand back");
endmodule : pccd_chk

// ### dv/pccd_flush_model.sv
// Flush engine model: raises flush_done_in after a set delay.
// Assumes flush_req stays high until flush_done_in is seen.
`timescale 1ns/1ps
module pccd_flush_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic flush_req,
    input wire logic [7:0] delay,
    output logic flush_done_in
);
    logic [7:0] cnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            flush_done_in <= 1'b0;
        end else if (!flush_req) begin
            cnt <= 8'h00;
            flush_done_in <= 1'b0;
        end else if (cnt >= delay) begin
            flush_done_in <= 1'b1;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : pccd_flush_model

// ### dv/power_condition_cmd_decoder_test.sv
// Bench for the power-condition decoder: APB master and scenarios.
// Assumes the flush engine model answers flush requests.
`timescale 1ns/1ps
module power_condition_cmd_decoder_test;
    import pccd_pkg::*;
    localparam logic [19:0] CHK_RES = {ST_CHECK, SK_ILLEGAL_REQ, ASC_INVALID_CDB};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] fdelay = 8'd40;
    logic [31:0] prdata, flush_lba, flush_count, rd, fl_lba, fl_cnt;
    logic pready, pslverr, flush_done_in, flush_req, timer_governed_power, unload_limits_on, cmd_done;
    logic err, req_seen, fdone_seen, sp_start, sp_stop;
    logic [4:0] timers_active, timer_zero_pulse, zp;
    pccd_spindle_t spindle;
    pccd_pstate_t power_state;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    logic [11:0] expl [7] = '{12'h100, 12'h201, 12'h212, 12'h223, 12'h304, 12'h315, 12'h315};
    logic [7:0] rsv [13] = '{8'h40, 8'h53, 8'h60, 8'h80, 8'h90, 8'hC0, 8'hF0, 8'h23, 8'h32, 8'h11, 8'h71,
        8'hA3, 8'hB2};

    pccd_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flush_done_in(flush_done_in), .flush_req(flush_req), .flush_lba(flush_lba), .flush_count(flush_count),
        .spindle(spindle), .power_state(power_state), .timer_governed_power(timer_governed_power),
        .unload_limits_on(unload_limits_on), .timers_active(timers_active),
        .timer_zero_pulse(timer_zero_pulse), .cmd_done(cmd_done));
    pccd_flush_model i_flush (.clk_sys(clk_sys), .resetn(resetn), .flush_req(flush_req), .delay(fdelay),
        .flush_done_in(flush_done_in));

    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chk("pready", 1, n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run_cmd(logic [31:0] w0, logic [31:0] w1, logic [31:0] w2, logic [19:0] exp);
        int n;
        n = 0;
        sp_start = 0;
        sp_stop = 0;
        zp = 0;
        req_seen = 0;
        fdone_seen = 0;
        apb(REG_CDB0, 1'b1, w0);
        apb(REG_CDB1, 1'b1, w1);
        apb(REG_CDB2, 1'b1, w2);
        apb(REG_CTRL, 1'b1, 32'h3);
        do begin
            @(posedge clk_sys);
            n++;
            if (spindle.valid === 1'b1) begin
                sp_start |= spindle.start;
                sp_stop |= spindle.stop;
            end
            zp |= timer_zero_pulse;
            if (flush_req === 1'b1) begin
                req_seen = 1;
                fl_lba = flush_lba;
                fl_cnt = flush_count;
            end
            fdone_seen |= flush_done_in;
        end while (cmd_done !== 1'b1 && n < 500);
        chk("cmd done", 1, n < 500);
        chk("done after flush", req_seen, fdone_seen);
        apb(REG_STATUS, 1'b0, 32'h0);
        chk("status", {12'h0, exp}, rd);
    endtask : run_cmd

    // Eject bit always sent as zero
    task automatic ss(logic [3:0] pc, logic [3:0] md, logic st, logic ok);
        run_cmd({4'h0, md, 16'h0, OPC_START_STOP}, {24'h0, pc, 3'h0, st}, 32'h0, ok ? 20'h0 : CHK_RES);
    endtask : ss

    task automatic fl(logic [31:0] lba, logic [15:0] cnt, logic imm, logic [31:0] exp_cnt);
        run_cmd({lba[23:16], lba[31:24], 6'h0, imm, 1'b0, OPC_FLUSH10}, {cnt[15:8], 8'h0, lba[7:0], lba[15:8]},
            {24'h0, cnt[7:0]}, imm ? CHK_RES : 20'h0);
        chk("flush issued", !imm, req_seen);
        if (!imm) begin
            chk("flush lba", lba, fl_lba);
            chk("flush count", exp_cnt, fl_cnt);
        end
    endtask : fl

    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        chk("state", PCCD_PS_ACTIVE, power_state);
        chk("governed", 1, timer_governed_power);
        chk("timers", 5'h1F, timers_active);
        apb(REG_TIMERS, 1'b0, 32'h0);
        chk("timer reg", 32'h001F1F1F, rd);
        apb(REG_LAST_BLOCK, 1'b0, 32'h0);
        chk("last block", 32'hFFFFFFFF, rd);
        apb(8'h40, 1'b0, 32'h0);
        chk("unmapped", 1, err);
        ss(PC_FORCE_STBY, MOD_1, 1'b0, 1'b1);
        chk("zero pulse", 5'h10, zp);
        chk("state", PCCD_PS_STBY_Y, power_state);
        foreach (expl[i]) begin
            ss(expl[i][11:8], expl[i][7:4], 1'b1, 1'b1);
            chk("state", expl[i][2:0], power_state);
            chk("governed", 0, timer_governed_power);
            chk("timers", 0, timers_active);
            chk("spindle", 0, sp_start | sp_stop);
        end
        ss(PC_FORCE_IDLE, MOD_0, 1'b0, 1'b0);
        ss(PC_HAND_BACK, MOD_0, 1'b0, 1'b1);
        chk("governed", 1, timer_governed_power);
        chk("timers", 5'h07, timers_active);
        ss(PC_FORCE_STBY, MOD_0, 1'b0, 1'b0);
        ss(PC_FORCE_IDLE, MOD_1, 1'b0, 1'b1);
        chk("zero pulse", 5'h02, zp);
        chk("state", PCCD_PS_IDLE_B, power_state);
        chk("governed", 1, timer_governed_power);
        foreach (rsv[i]) begin
            ss(rsv[i][7:4], rsv[i][3:0], 1'b0, 1'b0);
        end
        ss(PC_START_VALID, MOD_0, 1'b1, 1'b1);
        chk("spin start", 2'b10, {sp_start, sp_stop});
        ss(PC_START_VALID, MOD_0, 1'b0, 1'b1);
        chk("spin stop", 2'b01, {sp_start, sp_stop});
        ss(PC_ACTIVE, MOD_0, 1'b1, 1'b1);
        chk("start ignored", 2'b00, {sp_start, sp_stop});
        fl(32'h12345678, 16'h0102, 1'b0, 32'h00000102);
        fdelay <= 8'd1;
        fl(32'h00000010, 16'h0000, 1'b0, 32'hFFFFFFF0);
        fl(32'h00000020, 16'h0004, 1'b1, 32'h0);
        end_of_test();
    end
endmodule : power_condition_cmd_decoder_test

bind pccd_top pccd_chk i_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .flush_done_in(flush_done_in), .flush_req(flush_req),
    .flush_lba(flush_lba), .flush_count(flush_count), .spindle(spindle),
    .timer_governed_power(timer_governed_power), .unload_limits_on(unload_limits_on),
    .timers_active(timers_active), .timer_zero_pulse(timer_zero_pulse), .cmd_done(cmd_done));
